// *** hdl/cci_consts.svh ***
// constants for the control channel i2c configuration block
`ifndef CCI_CONSTS_SVH
`define CCI_CONSTS_SVH

// register offsets (byte addresses on the plain port)
`define CCI_ADDR_W          8
`define CCI_OFS_SETTINGS    8'h06
`define CCI_OFS_FARADDR     8'h07
`define CCI_RST_SETTINGS    8'h00
`define CCI_RST_FARADDR     8'h00

// settings register fields
`define CCI_BIT_SEQERR      7
`define CCI_BIT_SEQCLR      6
`define CCI_BIT_DLY_HI      4
`define CCI_BIT_DLY_LO      3
`define CCI_BIT_WRBLOCK     2
`define CCI_BIT_WDFAST      1
`define CCI_BIT_WDOFF       0
// far address register fields
`define CCI_BIT_ADDR_HI     7
`define CCI_BIT_ADDR_LO     1
`define CCI_BIT_HOLD        0

// timing, clock 100 MHz
`define CCI_CLK_MHZ         100
`define CCI_DLY_BASE_NS     250
`define CCI_DLY_STEP_NS     50
`define CCI_WD_FAST_US      50
`define CCI_WD_SLOW_US      1000000
`define CCI_WD_FAST_CYC     (`CCI_WD_FAST_US * `CCI_CLK_MHZ)
`define CCI_WD_SLOW_CYC     (`CCI_WD_SLOW_US * `CCI_CLK_MHZ)
`define CCI_SCL_HALF_NS     5000
`define CCI_SCL_HALF_CYC    ((`CCI_SCL_HALF_NS * `CCI_CLK_MHZ) / 1000)
`define CCI_RECOVER_PULSES  9

`endif

// *** hdl/cci_ctrl.sv ***
// control channel i2c settings, far address and bus watchdog
//
// Notes on behaviour
// (RULE1) forward channel sequence error sets read-only bit 7 of settings.
// (RULE2) writing bit 6 as one clears the sequence error flag.
// (RULE3) bits 4-3 delay data output after clock by 250 ns plus 50 ns steps.
// (RULE4) bit 2 set rejects register writes arriving over the control channel.
// (RULE5) that blocking leaves remote access to local i2c slaves untouched.
// (RULE6) watchdog timeout is 50 us with bit 1 set, one second otherwise.
// (RULE7) bit 0 disables the watchdog; enabled it spots free or hung bus.
// (RULE8) data high and bus idle for the timeout means the bus is free.
// (RULE9) data low and bus idle for the timeout gives nine clock pulses.
// (RULE10) bits 7-1 of far address register hold the serializer i2c address.
// (RULE11) a zero far address disables all i2c access to the serializer.
// (RULE12) on receive lock the far address loads from the link identifier.
// (RULE13) hold bit 0 stops that auto-load and keeps the written address.
// (RULE14) software writing an address should also set the hold bit.
// (RULE15) error flag is sticky until cleared; both registers reset to zero.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "cci_consts.svh"

module cci_ctrl
	import cci_pkg::*;
#(
	parameter int WD_SLOW_CYC = `CCI_WD_SLOW_CYC,
	parameter int WD_FAST_CYC = `CCI_WD_FAST_CYC,
	parameter int SCL_HALF_CYC = `CCI_SCL_HALF_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	// register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	input  wire logic       regRemote,
	output logic      [7:0] regRdata,
	// forward channel events
	input  wire logic       seqErrEvent,
	input  wire logic       rxLock,
	input  wire logic [6:0] linkFarId,
	// remote slave access path
	input  wire logic       remoteSlaveReq,
	output logic            remoteSlaveGrant,
	output logic            farAccessEnable,
	output logic      [6:0] farAddress,
	// local i2c bus
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	input  wire logic       sdaWant,
	output logic            sclOut,
	output logic            sclOe,
	output logic            sdaOut,
	output logic            sdaOe,
	output logic            busFree
);

	initial begin
		if (WD_FAST_CYC < 4 || WD_SLOW_CYC < WD_FAST_CYC ||
			SCL_HALF_CYC < 1 || SCL_HALF_CYC > 65535)
			$error("cci_ctrl: watchdog or scl counts out of range");
	end

	// ********************************************************************
	// input synchronisers
	// ********************************************************************
	logic [1:0] sclSync;
	logic [1:0] sdaSync;
	logic [1:0] lockSync;
	logic       sclD;
	logic       sdaD;
	logic       lockD;

	// pins and lock come from outside; two flops before any use
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclSync  <= 2'b11;
			sdaSync  <= 2'b11;
			lockSync <= 2'b00;
		end else begin
			sclSync  <= {sclSync[0], sclIn};
			sdaSync  <= {sdaSync[0], sdaIn};
			lockSync <= {lockSync[0], rxLock};
		end
	end

	// previous synchronised values for edge detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclD  <= 1'b1;
			sdaD  <= 1'b1;
			lockD <= 1'b0;
		end else begin
			sclD  <= sclSync[1];
			sdaD  <= sdaSync[1];
			lockD <= lockSync[1];
		end
	end

	wire sclFall  = sclD & ~sclSync[1];
	wire busEdge  = (sclD ^ sclSync[1]) | (sdaD ^ sdaSync[1]);
	wire lockRise = lockSync[1] & ~lockD;

	// ********************************************************************
	// register decode
	// ********************************************************************
	cci_req_s req;
	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr,
		rd: regRd, remote: regRemote};

	logic       seqErr;
	logic       seqClr;
	logic [1:0] dlySel;
	logic       wrBlock;
	logic       wdFast;
	logic       wdOff;
	logic [6:0] farAddr;
	logic       holdAddr;

	// remote writes are dropped while blocking is set
	wire wrOk    = req.wr & ~(req.remote & wrBlock); // see (RULE4)
	wire wrSet   = wrOk && req.addr == `CCI_OFS_SETTINGS;
	wire wrFar   = wrOk && req.addr == `CCI_OFS_FARADDR;
	wire clrReq  = wrSet && req.wdata[`CCI_BIT_SEQCLR]; // see (RULE2)
	wire autoLd  = lockRise & ~holdAddr; // see (RULE12) (RULE13)

	wire [7:0] settingsView = {seqErr, seqClr, 1'b0, dlySel, wrBlock,
		wdFast, wdOff};
	wire [7:0] farView = {farAddr, holdAddr};
	wire [7:0] readMux =
		(req.addr == `CCI_OFS_SETTINGS) ? settingsView :
		(req.addr == `CCI_OFS_FARADDR)  ? farView : 8'h00;

	// ********************************************************************
	// registers
	// ********************************************************************
	// settings fields; reset to zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			seqClr  <= 1'b0; // see (RULE15)
			dlySel  <= 2'b00;
			wrBlock <= 1'b0;
			wdFast  <= 1'b0;
			wdOff   <= 1'b0;
		end else if (wrSet) begin
			seqClr  <= req.wdata[`CCI_BIT_SEQCLR];
			dlySel  <= req.wdata[`CCI_BIT_DLY_HI:`CCI_BIT_DLY_LO];
			wrBlock <= req.wdata[`CCI_BIT_WRBLOCK];
			wdFast  <= req.wdata[`CCI_BIT_WDFAST];
			wdOff   <= req.wdata[`CCI_BIT_WDOFF];
		end
	end

	// sticky error flag; an event in the clear cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			seqErr <= 1'b0;
		else if (seqErrEvent)
			seqErr <= 1'b1; // see (RULE1) (RULE15)
		else if (clrReq)
			seqErr <= 1'b0; // see (RULE2)
	end

	// far address: software write, or link load on lock unless held
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			farAddr  <= 7'h00;
			holdAddr <= 1'b0;
		end else if (wrFar) begin
			farAddr  <= req.wdata[`CCI_BIT_ADDR_HI:`CCI_BIT_ADDR_LO];
			holdAddr <= req.wdata[`CCI_BIT_HOLD]; // see (RULE10)
		end else if (autoLd) begin
			farAddr  <= linkFarId; // see (RULE12)
		end
	end

	// read data register, valid the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			regRdata <= 8'h00;
		else if (req.rd)
			regRdata <= readMux;
		else
			regRdata <= 8'h00;
	end

	// access outputs held in flops
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			farAccessEnable  <= 1'b0;
			farAddress       <= 7'h00;
			remoteSlaveGrant <= 1'b0;
		end else begin
			farAccessEnable  <= farAddr != 7'h00; // see (RULE11)
			farAddress       <= farAddr;
			// write blocking does not gate slave pass-through
			remoteSlaveGrant <= remoteSlaveReq; // see (RULE5)
		end
	end

	// ********************************************************************
	// bus watchdog
	// ********************************************************************
	// wide counter: the one second count needs 27 bits at 100 MHz
	localparam int CW = $clog2(WD_SLOW_CYC + 1);
	wire [CW-1:0] wdLimit = wdFast ? CW'(WD_FAST_CYC - 1)
		: CW'(WD_SLOW_CYC - 1); // see (RULE6)

	cci_wd_e     wdState;
	cci_wd_e     next_wdState;
	logic [CW-1:0] idleCnt;
	logic [15:0] halfCnt;
	logic [4:0]  edgeCnt;
	logic        recSclLow;

	wire idleDone = idleCnt >= wdLimit;
	wire halfDone = halfCnt >= 16'(SCL_HALF_CYC - 1);
	wire recDone  = halfDone &&
		edgeCnt == 5'(2 * `CCI_RECOVER_PULSES - 1);

	// state choice: idle period ends as free (data high) or hung (low)
	always_comb begin
		next_wdState = wdState;
		case (wdState)
			WD_WATCH: begin
				if (!wdOff && idleDone && !busEdge)
					next_wdState = sdaSync[1] ? WD_FREE // see (RULE8)
						: WD_RECOVER; // see (RULE9)
			end
			WD_FREE: begin
				if (busEdge || wdOff)
					next_wdState = WD_WATCH;
			end
			WD_RECOVER: begin
				if (recDone)
					next_wdState = WD_WATCH;
			end
			default: next_wdState = WD_WATCH;
		endcase
	end

	// counters run only where their state needs them
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdState <= WD_WATCH;
			idleCnt <= '0;
			halfCnt <= 16'h0000;
			edgeCnt <= 5'h00;
			recSclLow <= 1'b0;
		end else begin
			wdState <= next_wdState;
			// any bus activity or a disabled watchdog restarts the wait
			if (busEdge || wdOff || wdState != WD_WATCH) // see (RULE7)
				idleCnt <= '0;
			else if (!idleDone)
				idleCnt <= idleCnt + CW'(1);
			if (wdState == WD_RECOVER && !halfDone) begin
				halfCnt <= halfCnt + 16'h0001;
			end else if (wdState == WD_RECOVER) begin
				halfCnt   <= 16'h0000;
				edgeCnt   <= edgeCnt + 5'h01;
				recSclLow <= ~recSclLow; // see (RULE9)
			end else begin
				halfCnt   <= 16'h0000;
				edgeCnt   <= 5'h00;
				recSclLow <= 1'b0;
			end
		end
	end

	// pin drives: scl pulled low during recovery only
	logic sdaDly;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclOut  <= 1'b1;
			sclOe   <= 1'b0;
			sdaOut  <= 1'b0;
			sdaOe   <= 1'b0;
			busFree <= 1'b0;
		end else begin
			sclOut  <= 1'b0;
			// current state keeps the last pulse as wide as the others
			sclOe   <= recSclLow && wdState == WD_RECOVER; // see (RULE9)
			// open drain: data low is driven, high is released
			sdaOut  <= 1'b0;
			sdaOe   <= ~sdaDly;
			busFree <= next_wdState == WD_FREE;
		end
	end

	// ********************************************************************
	// data output delay
	// ********************************************************************
	cci_sda_delay #(
		.MAX_CYC (40)
	) u_sdaDelay (
		.clk     (clk),
		.rst_b   (rst_b),
		.dlySel  (dlySel),
		.sclFall (sclFall),
		.sdaWant (sdaWant),
		.sdaOut  (sdaDly)
	);

endmodule // cci_ctrl

// *** hdl/cci_pkg.sv ***
// types for the control channel i2c configuration block
package cci_pkg;

	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic       remote;
	} cci_req_s;

	// bus watchdog states
	typedef enum logic [1:0] {
		WD_WATCH   = 2'b00,
		WD_FREE    = 2'b01,
		WD_RECOVER = 2'b10
	} cci_wd_e;

endpackage

// *** hdl/cci_sda_delay.sv ***
// programmable delay of the i2c data output after the clock edge
`timescale 1ns/1ps
`include "cci_consts.svh"

module cci_sda_delay
	import cci_pkg::*;
#(
	parameter int MAX_CYC = 40
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [1:0] dlySel,
	input  wire logic       sclFall,
	input  wire logic       sdaWant,
	output logic            sdaOut
);

	initial begin
		if (MAX_CYC < 2 || MAX_CYC > 255)
			$error("cci_sda_delay: MAX_CYC out of range");
	end

	// ********************************************************************
	// delay counter: 250 ns plus 50 ns per step
	// ********************************************************************
	localparam int BASE_CYC = (`CCI_DLY_BASE_NS * `CCI_CLK_MHZ) / 1000;
	localparam int STEP_CYC = (`CCI_DLY_STEP_NS * `CCI_CLK_MHZ) / 1000;

	logic [7:0] cnt;
	logic       pend;
	logic       pendVal;
	wire  [7:0] target = 8'(BASE_CYC + STEP_CYC * int'(dlySel));

	// the data output only changes once the delay after scl fall has run
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt     <= 8'h00;
			pend    <= 1'b0;
			pendVal <= 1'b1;
			sdaOut  <= 1'b1;
		end else if (sclFall) begin
			cnt     <= 8'h01;
			pend    <= 1'b1;
			pendVal <= sdaWant;
		end else if (pend && cnt >= target - 8'h01) begin
			pend    <= 1'b0;
			sdaOut  <= pendVal; // see (RULE3)
		end else if (pend) begin
			cnt     <= cnt + 8'h01;
		end
	end

endmodule // cci_sda_delay

// *** testbench/cci_ctrl_asserts.sv ***
// port checks for the control channel i2c block
`timescale 1ns/1ps

module cci_ctrl_asserts
	import cci_pkg::*;
#(
	parameter int WD_FAST_CYC = 100
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       regRd,
	input  wire logic [7:0] regRdata,
	input  wire logic       remoteSlaveReq,
	input  wire logic       remoteSlaveGrant,
	input  wire logic       farAccessEnable,
	input  wire logic [6:0] farAddress,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	input  wire logic       sclOut,
	input  wire logic       sclOe,
	input  wire logic       sdaOut,
	input  wire logic       busFree
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	int idle;

	// quiet-pin counter; the design's own count lags it by the synchroniser
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			idle <= 0;
		else
			idle <= ($changed(sclIn) || $changed(sdaIn)) ? 0 : idle + 1;

	// ****************************************
	// assertions
	// ****************************************
	a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data outside answer cycle");
	a_grant_open: assert property ($rose(remoteSlaveReq) |=> remoteSlaveGrant)
		else $error("remote slave access not granted");
	a_far_enable: assert property ($stable(farAddress) |->
		farAccessEnable == (farAddress != 7'h00))
		else $error("far access enable wrong");
	a_sda_drain: assert property (sdaOut == 1'b0)
		else $error("data line driven high");
	a_scl_low: assert property (sclOe |-> !sclOut)
		else $error("clock driven high");
	a_pulse_width: assert property ($rose(sclOe) |-> sclOe[*4] ##1 !sclOe)
		else $error("recovery pulse width wrong");
	a_free_quiet: assert property (busFree |-> !sclOe)
		else $error("clock pulses on free bus");
	a_free_high: assert property ($rose(busFree) |-> sdaIn)
		else $error("bus free with data low");
	a_free_late: assert property ($rose(busFree) |-> idle >= WD_FAST_CYC)
		else $error("bus free too early");
endmodule // cci_ctrl_asserts

bind cci_ctrl cci_ctrl_asserts #(.WD_FAST_CYC(WD_FAST_CYC)) chk (
	.clk(clk), .rst_b(rst_b), .regRd(regRd), .regRdata(regRdata),
	.remoteSlaveReq(remoteSlaveReq), .remoteSlaveGrant(remoteSlaveGrant),
	.farAccessEnable(farAccessEnable), .farAddress(farAddress),
	.sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe),
	.sdaOut(sdaOut), .busFree(busFree));

// *** testbench/cci_far_model.sv ***
// behavioural far-side serializer: lock, identifier and channel events
`timescale 1ns/1ps

module cci_far_model (
	input  wire logic       clk,
	output logic            rxLock,
	output logic      [6:0] linkFarId,
	output logic            seqErrEvent,
	output logic            remoteSlaveReq
);
	initial begin
		rxLock = 1'b0;
		linkFarId = 7'h55;
		seqErrEvent = 1'b0;
		remoteSlaveReq = 1'b0;
	end

	// the identifier stands a cycle before lock rises
	task lock_to(input logic [6:0] id);
		@(posedge clk) linkFarId <= id;
		@(posedge clk) rxLock <= 1'b1;
	endtask

	// identifier is no longer valid once lock drops
	task unlock;
		@(posedge clk) rxLock <= 1'b0;
		linkFarId <= ~linkFarId;
	endtask

	task seq_error;
		@(posedge clk) seqErrEvent <= 1'b1;
		@(posedge clk) seqErrEvent <= 1'b0;
	endtask

	task slave_req(input logic v);
		@(posedge clk) remoteSlaveReq <= v;
	endtask
endmodule // cci_far_model

// *** testbench/testbench.sv ***
// self-checking bench for the control channel i2c block
`timescale 1ns/1ps

module testbench;
	import cci_pkg::*;
	logic clk = 0, rst_b = 0, regWr = 0, regRd = 0, regRemote = 0;
	logic [7:0] regAddr = 0, regWdata = 0, regRdata;
	logic sdaWant = 1, sclBus = 1, sdaBus = 1, sclOut, sclOe, sdaOut, sdaOe;
	logic rxLock, seqErrEvent, remoteSlaveReq, grant, farEn, busFree, q;
	logic [6:0] farId, farAddress;
	logic [31:0] seed = 32'h81ed_f3c6;
	int num_errors = 0, checked = 0, n, p, i;
	// open-drain wires with pull-ups
	wire sclIn = sclBus & ~(sclOe & ~sclOut);
	wire sdaIn = sdaBus & ~(sdaOe & ~sdaOut);

	always #5 clk = ~clk;

	cci_ctrl #(.WD_SLOW_CYC(2000), .WD_FAST_CYC(100), .SCL_HALF_CYC(4)) DUT (
		.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRemote(regRemote),
		.regRdata(regRdata), .seqErrEvent(seqErrEvent), .rxLock(rxLock),
		.linkFarId(farId), .remoteSlaveReq(remoteSlaveReq),
		.remoteSlaveGrant(grant), .farAccessEnable(farEn),
		.farAddress(farAddress), .sclIn(sclIn), .sdaIn(sdaIn),
		.sdaWant(sdaWant), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .busFree(busFree));

	cci_far_model far (.clk(clk), .rxLock(rxLock), .linkFarId(farId),
		.seqErrEvent(seqErrEvent), .remoteSlaveReq(remoteSlaveReq));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] v, input logic rem);
		@(posedge clk) {regAddr, regWdata, regWr, regRemote} <= {a, v, 2'b10 | rem};
		@(posedge clk) {regWr, regRemote} <= 2'b00;
	endtask

	task rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) {regAddr, regRd} <= {a, 1'b1};
		@(posedge clk) regRd <= 1'b0;
		@(negedge clk) chk("read data", e, regRdata);
	endtask

	// quiet the bus after a short clock dip, then time the free flag
	task wd(input logic [7:0] v);
		wr(8'h06, v, 0);
		sclBus <= 0;
		repeat (4) @(posedge clk);
		sclBus <= 1;
		n = 0;
		while (busFree !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
	endtask

	// clock fall with a wanted data level; n is the launch delay
	task fall(input logic w);
		@(posedge clk) {sdaWant, sclBus} <= {w, 1'b0};
		n = 0;
		while (sdaOe !== !w && n < 100) begin @(negedge clk); n++; end
		@(posedge clk) sclBus <= 1;
	endtask

	task summarize;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1;
		rchk(8'h06, 8'h00);
		rchk(8'h07, 8'h00);
		rchk(8'h09, 8'h00);
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			wr(8'h06, seed[7:0], 0);
			rchk(8'h06, seed[7:0] & 8'h5f);
			wr(8'h07, seed[15:8] | 8'h01, 0);
			rchk(8'h07, seed[15:8] | 8'h01);
			rchk(8'h08 | 8'(seed[18:16]), 8'h00);
		end
		// sticky error and its clear
		wr(8'h06, 8'h00, 0);
		far.seq_error;
		rchk(8'h06, 8'h80);
		rchk(8'h06, 8'h80);
		wr(8'h06, 8'h40, 0);
		rchk(8'h06, 8'h40);
		// remote write blocking versus remote slave access
		wr(8'h07, 8'ha1, 0);
		wr(8'h06, 8'h04, 0);
		wr(8'h07, 8'h22, 1);
		rchk(8'h07, 8'ha1);
		far.slave_req(1);
		repeat (2) @(negedge clk);
		chk("grant", 1, grant);
		far.slave_req(0);
		wr(8'h06, 8'h00, 0);
		wr(8'h07, 8'h00, 1);
		repeat (2) @(negedge clk);
		chk("far enable", 0, farEn);
		// auto-load of a random identifier, then frozen address
		seed = lfsr(seed);
		far.lock_to(seed[6:0]);
		repeat (6) @(posedge clk);
		rchk(8'h07, {seed[6:0], 1'b0});
		chk("far address", seed[6:0], farAddress);
		far.unlock;
		wr(8'h07, 8'h23, 0);
		far.lock_to(7'h2c);
		repeat (6) @(posedge clk);
		rchk(8'h07, 8'h23);
		// data launch delay per setting
		for (i = 0; i < 4; i++) begin
			wr(8'h06, 8'(i * 8), 0);
			fall(1);
			fall(0);
			chk("delay", 1, 32'(n >= 25 + 5 * i && n <= 29 + 5 * i));
			fall(1);
		end
		wd(8'h02);
		chk("fast timeout", 1, 32'(n >= 100 && n <= 110));
		wd(8'h00);
		chk("slow timeout", 1, 32'(n >= 2000 && n <= 2010));
		wd(8'h03);
		chk("disabled", 5000, n);
		// hung bus: count recovery pulses
		wr(8'h06, 8'h02, 0);
		sdaBus <= 0;
		n = 0;
		while (sclOe !== 1'b1 && n < 400) begin @(negedge clk); n++; end
		p = 1;
		q = 1;
		repeat (80) begin
			@(negedge clk);
			p += 32'(sclOe & ~q);
			q = sclOe;
		end
		chk("pulses", 9, p);
		@(posedge clk) sdaBus <= 1;
		summarize;
	end

	// hang guard, well past the planned run
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		summarize;
	end
endmodule // testbench
